// File: pkg/ir_rx_pkg.sv
// Shared constants for the infrared receiver and decoder
package ir_rx_pkg;
  // Bit timing, in transmitter and receiver oscillator periods
  localparam int TX_OSC_PER_BIT = 128;
  localparam int RX_TX_RATIO = 3;
  localparam int BIT_CYCLES = TX_OSC_PER_BIT * RX_TX_RATIO;
  localparam int CONV_CYCLES = 384;
  localparam int DUTY_STEP = 6;
  localparam int CNT_W = 10;
  localparam int PHASE_W = 9;
  localparam logic [CNT_W-1:0] GAP_LIMIT = CNT_W'(2 * BIT_CYCLES);
  localparam logic [CNT_W-1:0] ACCEPT_CYCLES = CNT_W'(2 * BIT_CYCLES);
  localparam logic [PHASE_W-1:0] CONV_LAST = PHASE_W'(CONV_CYCLES - 1);
  // Manual switch-on needs the pin low for two clocks
  localparam logic [1:0] MANUAL_ON_LAST = 2'h1;
  // Word layout: two start bits then five command bits
  localparam int WORD_BITS = 5;
  localparam logic [2:0] POS_START0 = 3'h0;
  localparam logic [2:0] POS_START1 = 3'h1;
  localparam logic [2:0] POS_DATA = 3'h2;
  localparam logic [2:0] POS_LAST = 3'h6;
  // Analogue registers
  localparam int LVL_W = 6;
  localparam logic [LVL_W-1:0] LVL_MIN = 6'h00;
  localparam logic [LVL_W-1:0] LVL_MAX = 6'h3f;
  localparam logic [LVL_W-1:0] LVL_BASE = 6'h20;
  // Output group values
  localparam logic [3:0] PROG_INIT = 4'h1;
  localparam logic [3:0] OUT_ONES = 4'hf;
  localparam logic [3:0] OUT_ZEROS = 4'h0;
  // Analogue command codes (key index with select bit set)
  localparam logic [3:0] CMD_BASE = 4'h0;
  localparam logic [3:0] CMD_UP3 = 4'h1;
  localparam logic [3:0] CMD_UP2 = 4'h2;
  localparam logic [3:0] CMD_UP1 = 4'h3;
  localparam logic [3:0] CMD_OFF = 4'h4;
  localparam logic [3:0] CMD_DN3 = 4'h5;
  localparam logic [3:0] CMD_DN2 = 4'h6;
  localparam logic [3:0] CMD_DN1 = 4'h7;
  localparam logic [3:0] CMD_MUTE = 4'h8;
endpackage

// File: hw/pulse_width_dac.sv
// Pulse-width converter for one analogue register
module pulse_width_dac #(
  parameter int LVL_W = 6,
  parameter int PHASE_W = 9
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Level and shared conversion phase
  input wire logic [LVL_W-1:0] level,
  input wire logic [PHASE_W-1:0] phase,
  // Overrides
  input wire logic force_high,
  input wire logic force_low,
  // Pulsed output
  output logic pulse_out
);
  logic [PHASE_W-1:0] duty;

  // Top level 63 gives 378 of 384 clocks, so the output never sticks high
  assign duty = PHASE_W'(level) * PHASE_W'(ir_rx_pkg::DUTY_STEP); // see RULE_24

  always_ff @(posedge mclk) begin
    if (rst) begin
      pulse_out <= 1'b0;
    end else if (force_high) begin
      pulse_out <= 1'b1; // see RULE_09
    end else if (force_low) begin
      pulse_out <= 1'b0;
    end else begin
      pulse_out <= (phase < duty); // see RULE_08
    end
  end

  property p_force_high;
    @(posedge mclk) disable iff (rst) force_high |=> pulse_out;
  endproperty
  a_force_high: assert property (p_force_high) else $error("forced output not high"); // see RULE_09

  property p_duty_off;
    @(posedge mclk) disable iff (rst)
      (!force_high && !force_low && phase >= duty) |=> !pulse_out;
  endproperty
  a_duty_off: assert property (p_duty_off) else $error("pulse high past duty"); // see RULE_24
endmodule

// File: hw/ir_remote_receiver_decoder.sv
// Infrared remote receiver: bit decoder, word compare, outputs and analogue controls
// How it works
// RULE_01: Each bit is one when its pulse outlasts the gap before it.
// RULE_02: Data bits shift in only after the two start bits are seen.
// RULE_03: A finished word executes only when equal to the previous stored word.
// RULE_04: Programme commands load the code into the programme output buffer.
// RULE_05: Analogue commands show their code on aux outputs for the accept time.
// RULE_06: Programme code is kept and shown while hold input is low.
// RULE_07: Three 6-bit analogue registers step up or down, limits detected.
// RULE_08: Each register becomes a pulse output repeating every 384 clocks.
// RULE_09: Mute forces the first linear output high.
// RULE_10: All timing runs on the one oscillator clock and its counters.
// RULE_11: Reset gives stand-by, registers at half scale, programme code one.
// RULE_12: Stand-by ends on a programme command or pin low two clocks.
// RULE_13: Outside circuit holds reset for at least 100 us after power settles.
// RULE_14: Supply loss, seen as reset, returns the block to stand-by.
// RULE_15: Select bit zero: programme code equals key index, aux stays ones.
// RULE_16: Select bit one: analogue commands decoded, code shown on aux outputs.
// RULE_17: Mute clears on programme, first register step, base, or toggle.
// RULE_18: Stand-by: outputs zero, first linear one, others zero, pin high.
// RULE_19: ON and idle: aux ones, pin low, programme ones unless held.
// RULE_20: On/off pin is an input until low, then driven low.
// RULE_21: A bit cell is 128 transmitter periods, about 384 receiver clocks.
// RULE_22: Five command bits; bit zero picks programme or analogue command.
// RULE_23: Registers saturate at their limits instead of wrapping.
// RULE_24: Pulse duty is proportional to the register value.
module ir_remote_receiver_decoder (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Serial data and hold control
  input wire logic data_in,
  input wire logic hold_input_n,
  // On/off pin
  input wire logic power_on_off_pin_in,
  output logic power_on_off_pin_out,
  output logic power_on_off_pin_oe,
  // Output groups
  output logic [3:0] programme_out,
  output logic [3:0] aux_out,
  // Linear outputs
  output logic linear_out_one,
  output logic linear_out_two,
  output logic linear_out_three,
  // Status
  output logic standby_state,
  output logic mute_state
);
  localparam int CW = ir_rx_pkg::CNT_W;
  localparam int LW = ir_rx_pkg::LVL_W;

  function automatic logic [CW-1:0] sat_inc(input logic [CW-1:0] v);
    sat_inc = (&v) ? v : v + 1'b1;
  endfunction

  function automatic logic is_prog(input logic [4:0] w);
    is_prog = ~w[0]; // see RULE_22
  endfunction

  function automatic logic [3:0] cmd_code(input logic [4:0] w);
    cmd_code = w[4:1];
  endfunction

  logic [1:0] data_sync;
  logic [1:0] pin_sync;
  logic [1:0] hold_sync;
  logic data_prev;
  logic fall;
  logic [CW-1:0] high_cnt;
  logic [CW-1:0] low_cnt;
  logic bit_val;
  logic gap_timeout;
  logic [2:0] bit_position_counter;
  logic [4:0] incoming_shift_reg;
  logic [4:0] word_now;
  logic word_done;
  logic [4:0] compare_buffer_reg;
  logic buf_valid;
  logic match;
  logic exec_start;
  logic [CW-1:0] execute_sequencer_count;
  logic exec_busy;
  logic [4:0] cmd_reg;
  logic standby;
  logic mute;
  logic [3:0] prog_code;
  logic [1:0] pin_low_cnt;
  logic manual_on;
  logic [2:0] analogue_command_decode_up;
  logic [2:0] analogue_command_decode_dn;
  logic [3:0] code_now;
  logic analog_exec;
  logic [LW-1:0] level [3];
  logic [ir_rx_pkg::PHASE_W-1:0] conv_phase;
  logic [2:0] lin_vec;
  logic [2:0] lin_force_high;

  // Pins are asynchronous to mclk
  always_ff @(posedge mclk) begin
    data_sync <= {data_sync[0], data_in};
    pin_sync <= {pin_sync[0], power_on_off_pin_in};
    hold_sync <= {hold_sync[0], hold_input_n};
    data_prev <= data_sync[1];
  end

  assign fall = data_prev & ~data_sync[1];

  // Time ratio detector: tolerant of oscillator spread, unlike fixed-point sampling
  always_ff @(posedge mclk) begin
    if (rst) begin
      high_cnt <= '0;
      low_cnt <= '0;
    end else if (data_sync[1]) begin
      high_cnt <= data_prev ? sat_inc(high_cnt) : CW'(1);
    end else begin
      low_cnt <= fall ? CW'(1) : sat_inc(low_cnt);
    end
  end

  assign bit_val = high_cnt > low_cnt; // see RULE_01
  assign gap_timeout = !data_sync[1] && low_cnt == ir_rx_pkg::GAP_LIMIT; // see RULE_21

  always_ff @(posedge mclk) begin
    if (rst || gap_timeout) begin
      bit_position_counter <= ir_rx_pkg::POS_START0;
    end else if (fall) begin
      if (bit_position_counter == ir_rx_pkg::POS_START0) begin
        bit_position_counter <= bit_val ? ir_rx_pkg::POS_START0 : ir_rx_pkg::POS_START1;
      end else if (bit_position_counter == ir_rx_pkg::POS_START1) begin
        bit_position_counter <= bit_val ? ir_rx_pkg::POS_DATA : ir_rx_pkg::POS_START1;
      end else if (bit_position_counter == ir_rx_pkg::POS_LAST) begin
        bit_position_counter <= ir_rx_pkg::POS_START0;
      end else begin
        bit_position_counter <= bit_position_counter + 3'h1; // see RULE_10
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      incoming_shift_reg <= '0;
    end else if (fall && bit_position_counter >= ir_rx_pkg::POS_DATA) begin
      incoming_shift_reg <= {bit_val, incoming_shift_reg[4:1]}; // see RULE_02
    end
  end

  assign word_done = fall && bit_position_counter == ir_rx_pkg::POS_LAST;
  assign word_now = {bit_val, incoming_shift_reg[4:1]};
  assign match = buf_valid && word_now == compare_buffer_reg;
  assign exec_start = word_done && match && !exec_busy; // see RULE_03

  always_ff @(posedge mclk) begin
    if (rst) begin
      compare_buffer_reg <= '0;
      buf_valid <= 1'b0;
    end else if (word_done) begin
      compare_buffer_reg <= word_now;
      buf_valid <= 1'b1;
    end
  end

  // Accept time sequencer
  always_ff @(posedge mclk) begin
    if (rst) begin
      execute_sequencer_count <= '0;
      cmd_reg <= '0;
    end else if (exec_start) begin
      execute_sequencer_count <= ir_rx_pkg::ACCEPT_CYCLES; // see RULE_05
      cmd_reg <= word_now;
    end else if (exec_busy) begin
      execute_sequencer_count <= execute_sequencer_count - 1'b1;
    end
  end

  assign exec_busy = execute_sequencer_count != '0;
  assign code_now = cmd_code(word_now);
  assign analog_exec = exec_start && !is_prog(word_now) && !standby; // see RULE_16

  always_comb begin
    analogue_command_decode_up = {code_now == ir_rx_pkg::CMD_UP3,
                                  code_now == ir_rx_pkg::CMD_UP2,
                                  code_now == ir_rx_pkg::CMD_UP1};
    analogue_command_decode_dn = {code_now == ir_rx_pkg::CMD_DN3,
                                  code_now == ir_rx_pkg::CMD_DN2,
                                  code_now == ir_rx_pkg::CMD_DN1};
  end

  // Manual switch-on through the pin
  always_ff @(posedge mclk) begin
    if (rst || pin_sync[1]) begin
      pin_low_cnt <= 2'h0;
    end else if (pin_low_cnt != 2'h3) begin
      pin_low_cnt <= pin_low_cnt + 2'h1;
    end
  end

  assign manual_on = !pin_sync[1] && pin_low_cnt == ir_rx_pkg::MANUAL_ON_LAST; // see RULE_12

  // Reset stands for power-up and supply loss alike
  always_ff @(posedge mclk) begin
    if (rst) begin
      standby <= 1'b1; // see RULE_11, see RULE_14
    end else if (exec_start && is_prog(word_now)) begin
      standby <= 1'b0; // see RULE_12
    end else if (analog_exec && code_now == ir_rx_pkg::CMD_OFF) begin
      standby <= 1'b1; // see RULE_18
    end else if (manual_on) begin
      standby <= 1'b0; // see RULE_20
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      mute <= 1'b0;
    end else if (exec_start && is_prog(word_now)) begin
      mute <= 1'b0; // see RULE_17
    end else if (analog_exec) begin
      if (code_now == ir_rx_pkg::CMD_MUTE) begin
        mute <= ~mute;
      end else if (code_now == ir_rx_pkg::CMD_BASE || analogue_command_decode_up[0] ||
                   analogue_command_decode_dn[0]) begin
        mute <= 1'b0; // see RULE_17
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      prog_code <= ir_rx_pkg::PROG_INIT; // see RULE_11
    end else if (exec_start && is_prog(word_now)) begin
      prog_code <= code_now; // see RULE_04, see RULE_15
    end
  end

  // Analogue registers, index 0 is the first
  for (genvar i = 0; i < 3; i++) begin : g_lin
    always_ff @(posedge mclk) begin
      if (rst) begin
        level[i] <= ir_rx_pkg::LVL_BASE; // see RULE_11
      end else if (analog_exec) begin
        if (code_now == ir_rx_pkg::CMD_BASE) begin
          level[i] <= ir_rx_pkg::LVL_BASE;
        end else if (analogue_command_decode_up[i] && level[i] != ir_rx_pkg::LVL_MAX) begin
          level[i] <= level[i] + 1'b1; // see RULE_07, see RULE_23
        end else if (analogue_command_decode_dn[i] && level[i] != ir_rx_pkg::LVL_MIN) begin
          level[i] <= level[i] - 1'b1; // see RULE_07, see RULE_23
        end
      end
    end

    pulse_width_dac #(.LVL_W(LW), .PHASE_W(ir_rx_pkg::PHASE_W)) u_dac (
      .mclk(mclk),
      .rst(rst),
      .level(level[i]),
      .phase(conv_phase),
      .force_high(lin_force_high[i]),
      .force_low(standby),
      .pulse_out(lin_vec[i])
    );
  end

  assign lin_force_high = {1'b0, 1'b0, standby | mute}; // see RULE_09, see RULE_18

  always_ff @(posedge mclk) begin
    if (rst || conv_phase == ir_rx_pkg::CONV_LAST) begin
      conv_phase <= '0; // see RULE_08
    end else begin
      conv_phase <= conv_phase + 1'b1;
    end
  end

  assign linear_out_one = lin_vec[0];
  assign linear_out_two = lin_vec[1];
  assign linear_out_three = lin_vec[2];

  // Output groups
  always_ff @(posedge mclk) begin
    if (rst || standby) begin
      programme_out <= ir_rx_pkg::OUT_ZEROS; // see RULE_18
      aux_out <= ir_rx_pkg::OUT_ZEROS;
      power_on_off_pin_out <= 1'b1;
      power_on_off_pin_oe <= 1'b0;
    end else begin
      power_on_off_pin_out <= 1'b0; // see RULE_20
      power_on_off_pin_oe <= 1'b1;
      aux_out <= (exec_busy && !is_prog(cmd_reg)) ? cmd_code(cmd_reg)
                                                    : ir_rx_pkg::OUT_ONES; // see RULE_05, see RULE_19
      if ((exec_busy && is_prog(cmd_reg)) || !hold_sync[1]) begin
        programme_out <= prog_code; // see RULE_04, see RULE_06
      end else begin
        programme_out <= ir_rx_pkg::OUT_ONES; // see RULE_19
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      standby_state <= 1'b1;
      mute_state <= 1'b0;
    end else begin
      standby_state <= standby;
      mute_state <= mute;
    end
  end

  property p_standby_out;
    @(posedge mclk) disable iff (rst) standby && $past(standby) |->
      programme_out == ir_rx_pkg::OUT_ZEROS && aux_out == ir_rx_pkg::OUT_ZEROS && !power_on_off_pin_oe;
  endproperty
  a_standby_out: assert property (p_standby_out) else $error("stand-by outputs wrong"); // see RULE_18

  property p_mute_lin;
    @(posedge mclk) disable iff (rst) mute ##1 mute |=> linear_out_one;
  endproperty
  a_mute_lin: assert property (p_mute_lin) else $error("mute did not force output high"); // see RULE_09

  property p_sat_up;
    @(posedge mclk) disable iff (rst)
      analog_exec && analogue_command_decode_up[0] && level[0] == ir_rx_pkg::LVL_MAX
      |=> level[0] == ir_rx_pkg::LVL_MAX;
  endproperty
  a_sat_up: assert property (p_sat_up) else $error("register wrapped at maximum"); // see RULE_23

  property p_sat_dn;
    @(posedge mclk) disable iff (rst)
      analog_exec && analogue_command_decode_dn[2] && level[2] == ir_rx_pkg::LVL_MIN
      |=> level[2] == ir_rx_pkg::LVL_MIN;
  endproperty
  a_sat_dn: assert property (p_sat_dn) else $error("register wrapped at minimum"); // see RULE_23

  property p_step_dn;
    @(posedge mclk) disable iff (rst)
      analog_exec && analogue_command_decode_dn[1] && level[1] != ir_rx_pkg::LVL_MIN
      |=> level[1] == $past(level[1]) - 1'b1;
  endproperty
  a_step_dn: assert property (p_step_dn) else $error("register did not step down"); // see RULE_07

  property p_manual_on;
    // A fresh low after a high; the pin stays low for a while after an OFF command
    @(posedge mclk) disable iff (rst)
      standby && pin_sync[1] ##1 !pin_sync[1] ##1 !pin_sync[1] |=> !standby;
  endproperty
  a_manual_on: assert property (p_manual_on) else $error("manual on ignored"); // see RULE_12

  property p_reset_state;
    @(posedge mclk) rst |=> standby && level[2] == ir_rx_pkg::LVL_BASE &&
      prog_code == ir_rx_pkg::PROG_INIT && !mute;
  endproperty
  a_reset_state: assert property (p_reset_state) else $error("reset state wrong"); // see RULE_11

  property p_idle_aux;
    @(posedge mclk) disable iff (rst) !standby && !exec_busy |=>
      aux_out == ir_rx_pkg::OUT_ONES && power_on_off_pin_oe && !power_on_off_pin_out;
  endproperty
  a_idle_aux: assert property (p_idle_aux) else $error("idle outputs wrong"); // see RULE_19

  property p_prog_hold;
    @(posedge mclk) disable iff (rst) !standby && !hold_sync[1] |=> programme_out == $past(prog_code);
  endproperty
  a_prog_hold: assert property (p_prog_hold) else $error("held code not shown"); // see RULE_06

  property p_no_exec;
    @(posedge mclk) disable iff (rst) word_done && !match && !exec_busy |=> !exec_busy;
  endproperty
  a_no_exec: assert property (p_no_exec) else $error("executed unmatched word"); // see RULE_03

  property p_conv_wrap;
    @(posedge mclk) disable iff (rst) conv_phase == ir_rx_pkg::CONV_LAST |=> conv_phase == '0;
  endproperty
  a_conv_wrap: assert property (p_conv_wrap) else $error("conversion period wrong"); // see RULE_08

  c_prog_exec: cover property (@(posedge mclk) disable iff (rst) exec_start && is_prog(word_now));
  c_analog_exec: cover property (@(posedge mclk) disable iff (rst) analog_exec);
  c_manual_on: cover property (@(posedge mclk) disable iff (rst) standby && manual_on);
  c_mute: cover property (@(posedge mclk) disable iff (rst) $rose(mute));
endmodule

// File: tb/ir_tx_model.sv
// Transmitter model that drives serial command words into the receiver
module ir_tx_model (
  // Clock
  input wire logic mclk,
  // Serial data towards the receiver
  output logic data_out
);
  timeunit 1ns;
  timeprecision 1ns;

  initial data_out = 1'b0;

  // Hold one level for n clocks, changing just after the rising edge
  task automatic level(input logic v, input int n);
    @(posedge mclk);
    data_out <= v;
    repeat (n - 1) @(posedge mclk);
  endtask

  // Send one word reps times; unit is the short part, one third of a bit cell
  task automatic send(input logic [4:0] cmd, input int reps, input int unit);
    logic [6:0] bits;
    bits = {cmd, 2'b10};
    repeat (reps) begin
      for (int i = 0; i < 7; i++) begin
        level(1'b0, bits[i] ? unit : 2 * unit);
        level(1'b1, bits[i] ? 2 * unit : unit);
      end
      // Gap stays under the position timeout; a whole word outlasts the accept time
      level(1'b0, 400);
    end
  endtask
endmodule

// File: tb/ir_remote_receiver_decoder_tb_top.sv
// Self-checking bench for the infrared receiver and decoder
module ir_remote_receiver_decoder_tb_top;
  timeunit 1ns;
  timeprecision 1ns;

  localparam int NORMAL_UNIT = ir_rx_pkg::BIT_CYCLES / 3;
  // Short cells keep long step sequences affordable; only the ratio matters
  localparam int FAST_UNIT = 20;
  localparam int LIMIT = 95000;

  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic data_in;
  logic hold_input_n = 1'b1;
  logic ext_low = 1'b0;
  logic pin_wire;
  logic power_on_off_pin_out;
  logic power_on_off_pin_oe;
  logic [3:0] programme_out;
  logic [3:0] aux_out;
  logic linear_out_one;
  logic linear_out_two;
  logic linear_out_three;
  logic standby_state;
  logic mute_state;
  int error_cnt = 0;
  int checks_done = 0;
  int cyc = 0;

  always #25 mclk = ~mclk;

  // Pin has a pull-up; low when the block drives low or the switch closes
  assign pin_wire = ~((power_on_off_pin_oe & ~power_on_off_pin_out) | ext_low);

  ir_tx_model tx_u (
    .mclk(mclk),
    .data_out(data_in)
  );

  ir_remote_receiver_decoder dut_u (
    .mclk(mclk),
    .rst(rst),
    .data_in(data_in),
    .hold_input_n(hold_input_n),
    .power_on_off_pin_in(pin_wire),
    .power_on_off_pin_out(power_on_off_pin_out),
    .power_on_off_pin_oe(power_on_off_pin_oe),
    .programme_out(programme_out),
    .aux_out(aux_out),
    .linear_out_one(linear_out_one),
    .linear_out_two(linear_out_two),
    .linear_out_three(linear_out_three),
    .standby_state(standby_state),
    .mute_state(mute_state)
  );

  task automatic give_verdict();
    if (error_cnt == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      error_cnt++;
      give_verdict();
    end
  end

  // Wait n rising edges, then settle at the falling edge
  task automatic wt(input int n);
    repeat (n) @(posedge mclk);
    @(negedge mclk);
  endtask

  task automatic chk(input logic [9:0] got, input logic [9:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // High time of one linear output over a full conversion period
  task automatic lin(input int sel, input int exp_high);
    logic [9:0] n;
    logic v;
    n = 10'h000;
    repeat (ir_rx_pkg::CONV_CYCLES) begin
      @(negedge mclk);
      v = (sel == 1) ? linear_out_one : (sel == 2) ? linear_out_two : linear_out_three;
      if (v === 1'b1) n = n + 10'h001;
    end
    chk(n, 10'(exp_high));
  endtask

  function automatic logic [4:0] ana(input logic [3:0] c);
    return {c, 1'b1};
  endfunction

  function automatic logic [4:0] prog(input logic [3:0] k);
    return {k, 1'b0};
  endfunction

  task automatic check_standby();
    chk(10'(standby_state), 10'h001);
    chk(10'({programme_out, aux_out}), 10'h000);
    chk(10'({power_on_off_pin_out, power_on_off_pin_oe}), 10'h002);
    lin(1, ir_rx_pkg::CONV_CYCLES);
    lin(2, 0);
    lin(3, 0);
  endtask

  task automatic manual_on(input logic [7:0] exp_out);
    @(posedge mclk);
    ext_low <= 1'b1;
    repeat (4) @(posedge mclk);
    ext_low <= 1'b0;
    wt(6);
    chk(10'(standby_state), 10'h000);
    chk(10'({power_on_off_pin_out, power_on_off_pin_oe}), 10'h001);
    chk(10'({programme_out, aux_out}), 10'(exp_out));
  endtask

  initial begin
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    wt(4);
    check_standby();
    // Analogue commands are ignored in stand-by
    tx_u.send(ana(ir_rx_pkg::CMD_UP1), 2, FAST_UNIT);
    // The ignored word still runs the accept timer; let it expire before switch-on
    wt(420);
    chk(10'({standby_state, aux_out}), 10'h010);
    manual_on(8'hff);
    lin(1, 32 * ir_rx_pkg::DUTY_STEP);
    tx_u.send(prog(4'h5), 2, NORMAL_UNIT);
    wt(1);
    chk(10'({programme_out, aux_out}), 10'h05f);
    wt(800);
    chk(10'(programme_out), 10'h00f);
    @(posedge mclk);
    hold_input_n <= 1'b0;
    wt(5);
    chk(10'(programme_out), 10'h005);
    // A single new word only fills the buffer
    tx_u.send(prog(4'h9), 1, FAST_UNIT);
    wt(1);
    chk(10'(programme_out), 10'h005);
    tx_u.send(prog(4'h9), 1, FAST_UNIT);
    wt(1);
    chk(10'(programme_out), 10'h009);
    tx_u.send(ana(ir_rx_pkg::CMD_UP1), 4, FAST_UNIT);
    wt(1);
    chk(10'(aux_out), 10'(ir_rx_pkg::CMD_UP1));
    wt(800);
    chk(10'(aux_out), 10'h00f);
    lin(1, 35 * ir_rx_pkg::DUTY_STEP);
    tx_u.send(ana(ir_rx_pkg::CMD_MUTE), 2, FAST_UNIT);
    wt(1);
    chk(10'(mute_state), 10'h001);
    lin(1, ir_rx_pkg::CONV_CYCLES);
    tx_u.send(ana(ir_rx_pkg::CMD_UP1), 2, FAST_UNIT);
    wt(1);
    chk(10'(mute_state), 10'h000);
    lin(1, 36 * ir_rx_pkg::DUTY_STEP);
    // Step past the minimum; a wrap would show a long pulse
    tx_u.send(ana(ir_rx_pkg::CMD_DN3), 35, FAST_UNIT);
    lin(3, 0);
    tx_u.send(ana(ir_rx_pkg::CMD_UP3), 2, FAST_UNIT);
    lin(3, ir_rx_pkg::DUTY_STEP);
    for (int c = 0; c < 16; c++) begin
      if (c == 4) continue;
      tx_u.send(ana(4'(c)), 2, FAST_UNIT);
      wt(1);
      chk(10'(aux_out), 10'(c));
    end
    tx_u.send(ana(ir_rx_pkg::CMD_OFF), 2, FAST_UNIT);
    check_standby();
    tx_u.send(prog(4'h3), 2, FAST_UNIT);
    wt(1);
    chk(10'({standby_state, mute_state, programme_out}), 10'h003);
    lin(1, 32 * ir_rx_pkg::DUTY_STEP);
    // Supply loss in mid-run, with a full-length reset pulse
    @(posedge mclk);
    rst <= 1'b1;
    repeat (2000) @(posedge mclk);
    rst <= 1'b0;
    wt(4);
    check_standby();
    // Hold is still low, so the prepared programme code one shows
    manual_on({ir_rx_pkg::PROG_INIT, ir_rx_pkg::OUT_ONES});
    lin(2, 32 * ir_rx_pkg::DUTY_STEP);
    give_verdict();
  end
endmodule
